// >>> twts_pkg.sv
// Shared constants, register map and types of the two-wire transfer sequencer.
package twts_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets on the bus
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_DATA     = 8'h08;
  localparam logic [7:0] OFS_OWN      = 8'h0c;
  localparam logic [7:0] OFS_RATE     = 8'h10;
  localparam logic [7:0] OFS_IRQ_STS  = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int         CTRL_FLAG_POS = 7;
  localparam int         IRQ_W         = 2;
  localparam int         IRQ_FLAG_POS  = 0;
  localparam int         IRQ_WCOL_POS  = 1;
  localparam logic [7:0] CODE_MASK     = 8'hf8;
  localparam logic [7:0] CTRL_RST      = 8'h00;
  localparam logic [7:0] DATA_RST      = 8'hff;
  localparam logic [6:0] OWN_RST       = 7'h00;
  localparam logic [7:0] RATE_RST      = 8'h00;
  localparam logic [1:0] PRESC_RST     = 2'h0;

  // ---------------------------------------------------------------
  // Status codes, prescaler bits excluded
  // ---------------------------------------------------------------
  localparam logic [7:0] C_START     = 8'h08;
  localparam logic [7:0] C_REP_START = 8'h10;
  localparam logic [7:0] C_AW_ACK    = 8'h18;
  localparam logic [7:0] C_AW_NACK   = 8'h20;
  localparam logic [7:0] C_MD_ACK    = 8'h28;
  localparam logic [7:0] C_MD_NACK   = 8'h30;
  localparam logic [7:0] C_AR_ACK    = 8'h40;
  localparam logic [7:0] C_AR_NACK   = 8'h48;
  localparam logic [7:0] C_MRX_ACK   = 8'h50;
  localparam logic [7:0] C_MRX_NACK  = 8'h58;
  localparam logic [7:0] C_SAW_ACK   = 8'h60;
  localparam logic [7:0] C_SRX_ACK   = 8'h80;
  localparam logic [7:0] C_SRX_NACK  = 8'h88;
  localparam logic [7:0] C_SL_END    = 8'ha0;
  localparam logic [7:0] C_SAR_ACK   = 8'ha8;
  localparam logic [7:0] C_STX_ACK   = 8'hb8;
  localparam logic [7:0] C_STX_NACK  = 8'hc0;
  localparam logic [7:0] C_IDLE      = 8'hf8;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam logic [15:0] HALF_MIN  = 16'h0004;
  localparam logic [3:0]  BIT_ACK   = 4'h8;
  localparam logic [3:0]  BIT_DONE  = 4'h9;
  localparam logic [1:0]  STEP_LAST = 2'h2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       flag;
    logic       ack_en;
    logic       start;
    logic       stop;
    logic       wcol;
    logic       enable;
    logic [1:0] rsv;
  } twts_ctrl_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } twts_line_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_COND = 3'b001,
    S_BYTE = 3'b010,
    S_WAIT = 3'b011,
    S_STOP = 3'b100
  } twts_state_t;

endpackage : twts_pkg

// >>> twts_sync.sv
// Two-flop synchroniser for the bus lines.
`timescale 1ns/1ps
`default_nettype none
module twts_sync #(
  parameter int           W   = 2,
  parameter logic [W-1:0] RST = '1
) (
  input  wire logic         clk,    // Sampling clock.
  input  wire logic         rst_n,  // Asynchronous reset, active low.
  input  wire logic [W-1:0] d,      // Asynchronous inputs.
  output logic      [W-1:0] q       // Synchronised outputs.
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST;
      q      <= RST;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : twts_sync
`default_nettype wire

// >>> twts_core.sv
// Byte sequencer of the two-wire port with its bus register file.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Four modes: master transmit, master receive, slave transmit, slave receive.
// - Direction bit after address: high means read, low means write.
// - Acknowledge is SDA low in the ninth slot; high is not-acknowledge.
// - Every packet carries eight data bits then one acknowledge slot.
// - Status code sits in bits 7..3, prescaler below; mask 0xf8.
// - At each action point set the flag and load the matching code.
// - While the flag is set the transfer stays suspended.
// - Control write with flag and enable one sends the loaded byte.
// - After a sent byte and its acknowledge, the flag is set again.
// - Control write with flag, enable and stop one sends a STOP.
// - After a START the flag is set with code 0x08.
// - Address with write enters master transmit; with read, master receive.
// - Data write while the flag is low is dropped and sets collision.
// - The stop request clears itself once the STOP is on the bus.
module twts_core (
  input  wire logic         hclk,       // System clock.
  input  wire logic         hresetn,    // Asynchronous reset, active low.
  input  wire logic         hsel,       // Slave select.
  input  wire logic [31:0]  haddr,      // Byte address.
  input  wire logic [1:0]   htrans,     // Transfer type.
  input  wire logic         hwrite,     // Write when high.
  input  wire logic [2:0]   hsize,      // Transfer size, words only.
  input  wire logic [31:0]  hwdata,     // Write data.
  input  wire logic         hready,     // Bus ready.
  output logic              hreadyout,  // Slave ready.
  output logic              hresp,      // Response, always OKAY.
  output logic      [31:0]  hrdata,     // Read data.
  input  wire logic         scl_i,      // Clock line level.
  output logic              scl_o,      // Clock line drive value.
  output logic              scl_oe,     // Pulls the clock line low.
  input  wire logic         sda_i,      // Data line level.
  output logic              sda_o,      // Data line drive value.
  output logic              sda_oe,     // Pulls the data line low.
  output logic              irq         // Interrupt, level, active high.
);
  import twts_pkg::*;

  // ---------------------------------------------------------------
  // Line sampling
  // ---------------------------------------------------------------
  twts_line_t line_s;
  twts_line_t line_q;
  logic [1:0] line_sync;

  twts_sync #(.W(2), .RST(2'h3)) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({scl_i, sda_i}),
    .q     (line_sync)
  );
  assign line_s = twts_line_t'(line_sync);

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise  = line_s.scl & ~line_q.scl;
  assign scl_fall  = ~line_s.scl & line_q.scl;
  assign start_det = line_s.scl & line_q.scl & line_q.sda & ~line_s.sda;
  assign stop_det  = line_s.scl & line_q.scl & ~line_q.sda & line_s.sda;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic        dph_wr_r, dph_wr_nxt;
  logic [7:0]  dph_addr_r, dph_addr_nxt;
  logic [31:0] hrdata_nxt;
  logic        acc;
  logic        rd_irq;

  twts_ctrl_t              ctrl_r, ctrl_nxt;
  logic [7:0]              data_r, data_nxt;
  logic [4:0]              code_r, code_nxt;
  logic [1:0]              presc_r, presc_nxt;
  logic [6:0]              own_r, own_nxt;
  logic [7:0]              rate_r, rate_nxt;
  logic [IRQ_W-1:0]        irq_sts_r, irq_sts_nxt;
  logic [IRQ_W-1:0]        irq_mask_r, irq_mask_nxt;
  logic                    irq_nxt;

  assign acc    = hsel & htrans[1] & hready;
  assign rd_irq = acc & ~hwrite & (haddr[7:0] == OFS_IRQ_STS);

  always_comb begin
    dph_wr_nxt   = acc & hwrite & (hsize == 3'h2);
    dph_addr_nxt = acc ? haddr[7:0] : dph_addr_r;
    hrdata_nxt   = hrdata;
    if (acc && !hwrite) begin
      unique case (haddr[7:0])
        OFS_CTRL:     hrdata_nxt = {24'h0, ctrl_r};
        OFS_STATUS:   hrdata_nxt = {24'h0, code_r, 1'b0, presc_r};
        OFS_DATA:     hrdata_nxt = {24'h0, data_r};
        OFS_OWN:      hrdata_nxt = {24'h0, own_r, 1'b0};
        OFS_RATE:     hrdata_nxt = {24'h0, rate_r};
        OFS_IRQ_STS:  hrdata_nxt = {30'h0, irq_sts_r};
        OFS_IRQ_MASK: hrdata_nxt = {30'h0, irq_mask_r};
        default:      hrdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_r   <= 1'b0;
      dph_addr_r <= 8'h00;
      hrdata     <= 32'h0;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      dph_wr_r   <= dph_wr_nxt;
      dph_addr_r <= dph_addr_nxt;
      hrdata     <= hrdata_nxt;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end
  end

  logic wr_ctrl, wr_data, wr_stat, wr_own, wr_rate, wr_mask;
  assign wr_ctrl = dph_wr_r & (dph_addr_r == OFS_CTRL);
  assign wr_data = dph_wr_r & (dph_addr_r == OFS_DATA);
  assign wr_stat = dph_wr_r & (dph_addr_r == OFS_STATUS);
  assign wr_own  = dph_wr_r & (dph_addr_r == OFS_OWN);
  assign wr_rate = dph_wr_r & (dph_addr_r == OFS_RATE);
  assign wr_mask = dph_wr_r & (dph_addr_r == OFS_IRQ_MASK);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  twts_state_t state_r, state_nxt;
  logic [1:0]  step_r, step_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic [15:0] div_r, div_nxt;
  logic        master_r, master_nxt;
  logic        addr_ph_r, addr_ph_nxt;
  logic        rd_r, rd_nxt;
  logic        addressed_r, addressed_nxt;
  logic        busy_r, busy_nxt;
  logic        rep_r, rep_nxt;
  logic        ack_r, ack_nxt;
  logic        scl_oe_nxt, sda_oe_nxt;
  logic [15:0] half;
  logic        tick;
  logic        tx;
  logic        flag_set;
  logic        wcol_ev;
  logic [7:0]  done_code;

  // Code for a finished byte; ack low means the slot was acknowledged.
  function automatic logic [7:0] byte_code(input logic m, input logic a,
                                           input logic rd, input logic ack);
    logic [7:0] c;
    c = C_IDLE;
    if (m) begin
      if (a) c = rd ? (ack ? C_AR_NACK : C_AR_ACK) : (ack ? C_AW_NACK : C_AW_ACK);
      else   c = rd ? (ack ? C_MRX_NACK : C_MRX_ACK) : (ack ? C_MD_NACK : C_MD_ACK);
    end else begin
      if (a) c = rd ? C_SAR_ACK : C_SAW_ACK;
      else   c = rd ? (ack ? C_STX_NACK : C_STX_ACK) : (ack ? C_SRX_NACK : C_SRX_ACK);
    end
    return c;
  endfunction : byte_code

  // The prescaler stretches the half period by 1, 4, 16 or 64.
  assign half = (({8'h00, rate_r} + HALF_MIN) << {presc_r, 1'b0});
  assign tick = (div_r == half - 16'h0001);
  // master sends the address byte, slave takes it in; then direction picks the mode
  assign tx   = master_r ? (addr_ph_r | ~rd_r) : (~addr_ph_r & rd_r);
  assign done_code = byte_code(master_r, addr_ph_r, addr_ph_r ? data_r[0] : rd_r, ack_r);

  always_comb begin
    state_nxt     = state_r;
    step_nxt      = step_r;
    cnt_nxt       = cnt_r;
    master_nxt    = master_r;
    addr_ph_nxt   = addr_ph_r;
    rd_nxt        = rd_r;
    addressed_nxt = addressed_r;
    rep_nxt       = rep_r;
    ack_nxt       = ack_r;
    scl_oe_nxt    = scl_oe;
    sda_oe_nxt    = sda_oe;
    ctrl_nxt      = ctrl_r;
    data_nxt      = data_r;
    code_nxt      = code_r;
    presc_nxt     = wr_stat ? hwdata[1:0] : presc_r;
    own_nxt       = wr_own ? hwdata[7:1] : own_r;
    rate_nxt      = wr_rate ? hwdata[7:0] : rate_r;
    irq_mask_nxt  = wr_mask ? hwdata[IRQ_W-1:0] : irq_mask_r;
    flag_set      = 1'b0;
    wcol_ev       = 1'b0;
    busy_nxt      = start_det ? 1'b1 : (stop_det ? 1'b0 : busy_r);
    // Stretch is respected: the divider is held at zero while another party holds SCL low.
    div_nxt       = 16'h0000;
    if ((state_r == S_COND || state_r == S_STOP || (state_r == S_BYTE && master_r))
        && (scl_oe || line_s.scl)) begin
      div_nxt = tick ? 16'h0000 : div_r + 16'h0001;
    end

    if (wr_ctrl) begin
      ctrl_nxt.ack_en = hwdata[6];
      ctrl_nxt.start  = hwdata[5];
      ctrl_nxt.stop   = hwdata[4];
      ctrl_nxt.enable = hwdata[2];
      if (hwdata[CTRL_FLAG_POS]) begin
        ctrl_nxt.flag = 1'b0;
      end
    end
    if (wr_data) begin
      if (ctrl_r.flag) begin
        data_nxt      = hwdata[7:0];
        ctrl_nxt.wcol = 1'b0;
      end else begin
        ctrl_nxt.wcol = 1'b1;
        wcol_ev       = 1'b1;
      end
    end

    unique case (state_r)
      S_IDLE: begin
        scl_oe_nxt = 1'b0;
        sda_oe_nxt = 1'b0;
        if (ctrl_r.enable && ctrl_r.start && !ctrl_r.flag && !busy_r) begin
          state_nxt  = S_COND;
          step_nxt   = 2'h0;
          master_nxt = 1'b1;
          rep_nxt    = 1'b0;
        end else if (ctrl_r.enable && start_det) begin
          // slave side joins on a foreign START
          state_nxt   = S_BYTE;
          cnt_nxt     = 4'h0;
          addr_ph_nxt = 1'b1;
          master_nxt  = 1'b0;
        end
      end
      S_COND: begin
        if (tick) begin
          step_nxt = step_r + 2'h1;
          unique case (step_r)
            2'h0: scl_oe_nxt = 1'b0;
            2'h1: sda_oe_nxt = 1'b1;
            default: begin
              scl_oe_nxt  = 1'b1;
              state_nxt   = S_WAIT;
              addr_ph_nxt = 1'b1;
              flag_set    = 1'b1;
              code_nxt    = rep_r ? C_REP_START[7:3] : C_START[7:3];
            end
          endcase
        end
      end
      S_WAIT: begin
        // held here until software clears the flag; SCL low unless entered on a slave session end
        if (!ctrl_nxt.flag) begin
          if (ctrl_nxt.stop && master_r) begin
            state_nxt  = S_STOP;
            step_nxt   = 2'h0;
            sda_oe_nxt = 1'b1;
          end else if (ctrl_nxt.start && master_r) begin
            state_nxt  = S_COND;
            step_nxt   = 2'h0;
            rep_nxt    = 1'b1;
            sda_oe_nxt = 1'b0;
          end else if (master_r || addressed_r) begin
            state_nxt  = S_BYTE;
            cnt_nxt    = 4'h0;
            sda_oe_nxt = tx & ~data_nxt[7];
            scl_oe_nxt = master_r;
          end else begin
            state_nxt    = S_IDLE;
            ctrl_nxt.stop = 1'b0;
          end
        end
      end
      S_BYTE: begin
        if (master_r && tick) begin
          scl_oe_nxt = ~scl_oe;
        end
        if (scl_rise) begin
          cnt_nxt = cnt_r + 4'h1;
          // eight bits then the acknowledge slot
          if (cnt_r < BIT_ACK) begin
            data_nxt = {data_r[6:0], line_s.sda};
          end else begin
            // low in this slot is acknowledge
            ack_nxt = line_s.sda;
          end
        end else if (scl_fall && cnt_r != 4'h0) begin
          if (cnt_r < BIT_ACK) begin
            sda_oe_nxt = tx & ~data_r[7];
          end else if (cnt_r == BIT_ACK) begin
            if (tx) begin
              sda_oe_nxt = 1'b0;
            end else if (!master_r && addr_ph_r) begin
              // Our own address only; anything else leaves the bus alone.
              sda_oe_nxt = (data_r[7:1] == own_r) && ctrl_r.ack_en;
              if (!((data_r[7:1] == own_r) && ctrl_r.ack_en)) begin
                state_nxt = S_IDLE;
              end
            end else begin
              sda_oe_nxt = ctrl_r.ack_en;
            end
          end else begin
            sda_oe_nxt = 1'b0;
            scl_oe_nxt = 1'b1;
            state_nxt  = S_WAIT;
            flag_set   = 1'b1;
            code_nxt   = done_code[7:3];
            if (addr_ph_r) begin
              // read is a high direction bit
              rd_nxt        = data_r[0];
              addr_ph_nxt   = 1'b0;
              addressed_nxt = ~master_r;
            end else if (!master_r && ack_r) begin
              addressed_nxt = 1'b0;
            end
          end
        end
      end
      S_STOP: begin
        if (tick) begin
          step_nxt = step_r + 2'h1;
          unique case (step_r)
            2'h0: scl_oe_nxt = 1'b0;
            2'h1: sda_oe_nxt = 1'b0;
            default: begin
              ctrl_nxt.stop = 1'b0;
              master_nxt    = 1'b0;
              state_nxt     = S_IDLE;
              code_nxt      = C_IDLE[7:3];
            end
          endcase
        end
      end
      default: state_nxt = S_IDLE;
    endcase

    // A STOP or START from elsewhere ends our slave session; a repeated
    // START aimed at us again is then missed until the next START.
    if (!master_r && state_r != S_IDLE && (stop_det || start_det)) begin
      sda_oe_nxt    = 1'b0;
      scl_oe_nxt    = 1'b0;
      addressed_nxt = 1'b0;
      state_nxt     = addressed_r ? S_WAIT : S_IDLE;
      if (addressed_r) begin
        flag_set = 1'b1;
        code_nxt = C_SL_END[7:3];
      end
    end

    // disabled port releases lines and idles
    if (!ctrl_nxt.enable) begin
      state_nxt     = S_IDLE;
      master_nxt    = 1'b0;
      addressed_nxt = 1'b0;
      scl_oe_nxt    = 1'b0;
      sda_oe_nxt    = 1'b0;
    end

    // Hardware set wins over a clear in the same cycle.
    if (flag_set) begin
      ctrl_nxt.flag = 1'b1;
    end
    irq_sts_nxt = rd_irq ? '0 : irq_sts_r;
    irq_sts_nxt[IRQ_FLAG_POS] = irq_sts_nxt[IRQ_FLAG_POS] | flag_set;
    irq_sts_nxt[IRQ_WCOL_POS] = irq_sts_nxt[IRQ_WCOL_POS] | wcol_ev;
    irq_nxt = |(irq_sts_nxt & irq_mask_nxt);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_q      <= 2'h3;
      state_r     <= S_IDLE;
      step_r      <= 2'h0;
      cnt_r       <= 4'h0;
      div_r       <= 16'h0000;
      master_r    <= 1'b0;
      addr_ph_r   <= 1'b0;
      rd_r        <= 1'b0;
      addressed_r <= 1'b0;
      busy_r      <= 1'b0;
      rep_r       <= 1'b0;
      ack_r       <= 1'b1;
      scl_oe      <= 1'b0;
      sda_oe      <= 1'b0;
      scl_o       <= 1'b0;
      sda_o       <= 1'b0;
      ctrl_r      <= CTRL_RST;
      data_r      <= DATA_RST;
      code_r      <= C_IDLE[7:3];
      presc_r     <= PRESC_RST;
      own_r       <= OWN_RST;
      rate_r      <= RATE_RST;
      irq_sts_r   <= '0;
      irq_mask_r  <= '0;
      irq         <= 1'b0;
    end else begin
      line_q      <= line_s;
      state_r     <= state_nxt;
      step_r      <= step_nxt;
      cnt_r       <= cnt_nxt;
      div_r       <= div_nxt;
      master_r    <= master_nxt;
      addr_ph_r   <= addr_ph_nxt;
      rd_r        <= rd_nxt;
      addressed_r <= addressed_nxt;
      busy_r      <= busy_nxt;
      rep_r       <= rep_nxt;
      ack_r       <= ack_nxt;
      scl_oe      <= scl_oe_nxt;
      sda_oe      <= sda_oe_nxt;
      scl_o       <= 1'b0;
      sda_o       <= 1'b0;
      ctrl_r      <= ctrl_nxt;
      data_r      <= data_nxt;
      code_r      <= code_nxt;
      presc_r     <= presc_nxt;
      own_r       <= own_nxt;
      rate_r      <= rate_nxt;
      irq_sts_r   <= irq_sts_nxt;
      irq_mask_r  <= irq_mask_nxt;
      irq         <= irq_nxt;
    end
  end

endmodule : twts_core
`default_nettype wire

// >>> twts_monitor.sv
// Checker of the register bus and line drive of the two-wire sequencer.
`timescale 1ns/1ps
`default_nettype none
module twts_monitor
  import twts_pkg::*;
(
  input wire logic        hclk,      // Clock.
  input wire logic        hresetn,   // Reset, active low.
  input wire logic        hsel,      // Select.
  input wire logic [31:0] haddr,     // Address.
  input wire logic [1:0]  htrans,    // Transfer type.
  input wire logic        hwrite,    // Write.
  input wire logic [31:0] hwdata,    // Write data.
  input wire logic        hready,    // Bus ready.
  input wire logic        hreadyout, // Slave ready.
  input wire logic        hresp,     // Response.
  input wire logic [31:0] hrdata,    // Read data.
  input wire logic        scl_o,     // Clock drive value.
  input wire logic        scl_oe,    // Clock pull.
  input wire logic        sda_o,     // Data drive value.
  input wire logic        sda_oe,    // Data pull.
  input wire logic        irq        // Interrupt.
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [3:0] acc_r, acc_nxt;
  logic       ctl_ph_r, ctl_ph_nxt;
  logic       en_r, en_nxt;
  wire logic  acc = hsel & htrans[1] & hready;
  // The enable bit is followed from control writes, taken in their data phase.
  always_comb begin
    acc_nxt    = {acc_r[2:0], acc};
    ctl_ph_nxt = acc & hwrite & (haddr[7:0] == OFS_CTRL);
    en_nxt     = ctl_ph_r ? hwdata[2] : en_r;
  end
  // Only a bus access may take the interrupt down, so history is kept.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r    <= 4'h0;
      ctl_ph_r <= 1'b0;
      en_r     <= 1'b0;
    end else begin
      acc_r    <= acc_nxt;
      ctl_ph_r <= ctl_ph_nxt;
      en_r     <= en_nxt;
    end
  end
  sequence rd_at(logic [7:0] a);
    acc && !hwrite && haddr[7:0] == a;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
  a_ready_high: assert property (hreadyout) else $error("wait state inserted");
  a_drive_open: assert property (!scl_o && !sda_o) else $error("line driven high");
  a_status_pad: assert property (rd_at(OFS_STATUS) |=> hrdata[31:8] == 24'h0 && !hrdata[2])
    else $error("status field out of place");
  a_data_byte: assert property (rd_at(OFS_DATA) |=> hrdata[31:8] == 24'h0)
    else $error("data wider than a byte");
  a_unmapped_zero: assert property (rd_at(8'h1c) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_irq_width: assert property (rd_at(OFS_IRQ_STS) |=> hrdata[31:2] == 30'h0)
    else $error("event bits out of place");
  a_irq_cause: assert property ($fell(irq) |-> (|acc_r))
    else $error("interrupt fell with no access");
  a_idle_release: assert property (!en_r |-> !scl_oe && !sda_oe)
    else $error("lines driven while disabled");
endmodule : twts_monitor
bind twts_core twts_monitor mon_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hreadyout, .hresp, .hrdata, .scl_o, .scl_oe, .sda_o, .sda_oe, .irq);
`default_nettype wire

// >>> twts_slave_model.sv
// Behavioural remote slave that acknowledges its own address.
`timescale 1ns/1ps
`default_nettype none
module twts_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input  wire logic scl,    // Clock line level.
  input  wire logic sda,    // Data line level.
  output logic      sda_oe  // Pulls the data line low.
);
  logic [3:0] cnt;
  logic [7:0] sh;
  logic       first;
  logic       rdm;
  initial begin
    cnt = 4'h0; first = 1'b0; rdm = 1'b0; sda_oe = 1'b0;
  end
  always @(negedge sda) if (scl) begin
    cnt = 4'h0;
    first = 1'b1;
  end
  // Eight bits MSB first, direction last.
  always @(posedge scl) begin
    if (cnt < 4'h8) sh = {sh[6:0], sda};
    cnt = cnt + 4'h1;
  end
  // Acknowledge low, released otherwise; a read returns released ones.
  always @(negedge scl) begin
    if (cnt == 4'h8) begin
      if (first) rdm = sh[0];
      sda_oe = first ? (sh[7:1] == ADDR) : !rdm;
    end else if (cnt == 4'h9) begin
      sda_oe = 1'b0;
      cnt = 4'h0;
      first = 1'b0;
    end
  end
endmodule : twts_slave_model
`default_nettype wire

// >>> twts_core_tb.sv
// Self-checking bench of the two-wire sequencer through its register bus.
`timescale 1ns/1ps
`default_nettype none
module twts_core_tb;
  import twts_pkg::*;
  localparam logic [6:0] SLV = 7'h2a;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic        scl_o, scl_oe, sda_o, sda_oe, m_oe;
  int          n_mismatch, checks_done, cyc, i;
  logic [7:0]  adr [3];
  logic [7:0]  exp [3];
  wire logic   scl = !scl_oe;
  wire logic   sda = !(sda_oe | m_oe);
  twts_core dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .scl_i(scl), .scl_o, .scl_oe,
    .sda_i(sda), .sda_o, .sda_oe, .irq);
  twts_slave_model #(.ADDR(SLV)) mdl_u (.scl, .sda, .sda_oe(m_oe));
  always #4 hclk = ~hclk;
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask : cmp
  task automatic poll(input int pos, input logic v);
    for (int j = 0; j < 400; j++) begin
      bus(1'b0, OFS_CTRL, 32'h0);
      if (rd[pos] === v) break;
    end
    // A poll that never sees the bit ends the run as a failure.
    if (rd[pos] !== v) begin
      n_mismatch++;
      end_of_test();
    end
  endtask : poll
  task automatic code(input logic [7:0] c, input logic [7:0] want);
    bus(1'b1, OFS_CTRL, {24'h0, c});
    poll(CTRL_FLAG_POS, 1'b1);
    bus(1'b0, OFS_STATUS, 32'h0);
    cmp(rd, {24'h0, want});
  endtask : code
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // A run that reaches 30000 clock cycles ends here as a failure.
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    hclk = 0; hresetn = 0; hsel = 0; htrans = 0; haddr = 0; hwrite = 0; hwdata = 0;
    n_mismatch = 0; checks_done = 0; cyc = 0;
    adr = '{{SLV, 1'b0}, {SLV, 1'b1}, {SLV ^ 7'h1, 1'b0}};
    exp = '{C_AW_ACK, C_AR_ACK, C_AW_NACK};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, OFS_STATUS, 32'h0); cmp(rd, 32'hf8);
    bus(1'b0, 8'h1c, 32'h0); cmp(rd, 32'h0);
    bus(1'b1, OFS_STATUS, 32'h3);
    bus(1'b0, OFS_STATUS, 32'h0); cmp(rd & {24'h0, CODE_MASK}, {24'h0, C_IDLE});
    cmp(rd, 32'hfb);
    bus(1'b1, OFS_STATUS, 32'h0);
    $display("test reset values done");
    bus(1'b1, OFS_IRQ_MASK, 32'h3);
    bus(1'b1, OFS_DATA, 32'h11);
    bus(1'b0, OFS_DATA, 32'h0); cmp(rd, 32'hff);
    bus(1'b0, OFS_CTRL, 32'h0); cmp(rd, 32'h08);
    cmp({31'h0, irq}, 32'h1);
    bus(1'b0, OFS_IRQ_STS, 32'h0); cmp(rd, 32'h2);
    repeat (3) @(posedge hclk);
    cmp({31'h0, irq}, 32'h0);
    $display("test write collision done");
    bus(1'b1, OFS_CTRL, 32'h20);
    repeat (60) @(posedge hclk);
    cmp({30'h0, scl_oe, sda_oe}, 32'h0);
    bus(1'b0, OFS_STATUS, 32'h0); cmp(rd, 32'hf8);
    $display("test disabled start done");
    for (i = 0; i < 3; i++) begin
      code(8'ha4, C_START);
      cmp({31'h0, irq}, 32'h1);
      bus(1'b0, OFS_IRQ_STS, 32'h0); cmp(rd, 32'h1);
      bus(1'b1, OFS_DATA, {24'h0, adr[i]});
      code(8'h84, exp[i]);
      if (i == 0) begin
        bus(1'b1, OFS_DATA, 32'h5a);
        code(8'h84, C_MD_ACK);
      end
      if (i == 1) begin
        code(8'h84, C_MRX_NACK);
        bus(1'b0, OFS_DATA, 32'h0); cmp(rd, 32'hff);
      end
      bus(1'b1, OFS_CTRL, 32'h94);
      poll(4, 1'b0);
      cmp(rd & 32'h10, 32'h0);
      bus(1'b0, OFS_STATUS, 32'h0); cmp(rd, {24'h0, C_IDLE});
      $display("test transfer %0d done", i);
    end
    end_of_test();
  end
endmodule : twts_core_tb
`default_nettype wire
